// ### hw/pdipc_defines.svh
/*
 * Constants of the port direction, input and pull control block: register
 * offsets, reset values and pin group masks.
 * Assumes a byte-wide register port with a 16-bit address.
 */
`ifndef PDIPC_DEFINES_SVH
`define PDIPC_DEFINES_SVH

// Register byte addresses
`define PDIPC_OFS_OUTPUT_LATCH   16'h0280
`define PDIPC_OFS_PIN_READBACK   16'h0281
`define PDIPC_OFS_PIN_DIRECTION  16'h0282
`define PDIPC_OFS_PULL_ENABLE    16'h0284
`define PDIPC_OFS_PULL_POLARITY  16'h0285

// Reset values
`define PDIPC_RST_OUTPUT_LATCH   8'h00
`define PDIPC_RST_PIN_DIRECTION  8'h00
`define PDIPC_RST_PULL_ENABLE    8'hFF
`define PDIPC_RST_PULL_POLARITY  8'h00

// Bit groups of the port
`define PDIPC_ALL_PINS           8'hFF
`define PDIPC_NO_PINS            8'h00

`endif

// ### hw/pdipc_pkg.sv
/*
 * Types of the port direction, input and pull control block.
 * Assumes the constants header is included by the modules that need it.
 */
package pdipc_pkg;

    // Whole state of the port controller
    typedef struct packed {
        logic [7:0] latch;    // Output latch
        logic [7:0] dir;      // Pin direction
        logic [7:0] pe;       // Pull enable
        logic [7:0] pol;      // Pull polarity select
        logic [7:0] rdata;    // Read data
        logic [7:0] pout;     // Pin output level
        logic [7:0] oe;       // Pin output enable
        logic [7:0] ie;       // Pin input buffer enable
        logic [7:0] pull_en;  // Pull device active
        logic [7:0] pull_dn;  // Pull device is pull-down
        logic [7:0] per_in;   // Gated pin levels to peripherals
    } pdipc_state_t;

    // Address and data types of the register port
    typedef logic [15:0] pdipc_addr_t;
    typedef logic [7:0]  pdipc_byte_t;

endpackage

// ### hw/pdipc_sync.sv
/*
 * Two-stage synchroniser for the pin input levels.
 * Assumes the inputs are asynchronous to sys_clk.
 */
`timescale 1ns/1ns
`default_nettype none

module pdipc_sync #(
    parameter int W = 8                  // Number of pins
) (
    input  wire logic         sys_clk,   // System clock
    input  wire logic         rst_b,     // Asynchronous reset, active low
    input  wire logic [W-1:0] async_in,  // Raw pin levels
    output logic      [W-1:0] sync_out   // Synchronised levels
);

    // Both stages of the synchroniser
    typedef struct packed {
        logic [W-1:0] s1;  // First stage, read only by the second
        logic [W-1:0] s2;  // Second stage
    } pdipc_sync_st_t;

    pdipc_sync_st_t st_q;  // Registered state
    pdipc_sync_st_t st_d;  // Next state

    // Shift the levels through the two stages
    always_comb begin
        st_d    = st_q;
        st_d.s1 = async_in;
        st_d.s2 = st_q.s1;
    end

    // Register the stages
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign sync_out = st_q.s2;

endmodule

`default_nettype wire

// ### hw/pdipc_top.sv
/*
 * Port direction, input and pull control for one 8-bit general purpose
 * port: output latch, pin level readback, direction, pull enable and pull
 * polarity registers, with peripheral overrides of the pin direction.
 * Assumes peripheral controls come from logic on sys_clk and pin levels
 * come from outside, asynchronous to it.
 */
`timescale 1ns/1ns
`default_nettype none
`include "pdipc_defines.svh"

module pdipc_top (
    input  wire logic               sys_clk,      // System clock, 250 MHz
    input  wire logic               rst_b,        // Asynchronous reset, active low
    input  wire pdipc_pkg::pdipc_addr_t addr,     // Register address
    input  wire pdipc_pkg::pdipc_byte_t wdata,    // Write data
    input  wire logic               wr,           // Write strobe
    input  wire logic               rd,           // Read strobe
    output var pdipc_pkg::pdipc_byte_t rdata,     // Read data, cycle after rd
    input  wire logic [7:0]         pin_in,       // Pin input levels
    output logic      [7:0]         pin_out,      // Pin output levels
    output logic      [7:0]         pin_oe,       // Pin output enables
    output logic      [7:0]         pin_ie,       // Pin input buffer enables
    output logic      [7:0]         pull_en,      // Pull device active
    output logic      [7:0]         pull_dn,      // Pull-down when high, pull-up when low
    output logic      [7:0]         per_in,       // Synchronised levels to peripherals
    input  wire logic               lcd_en,       // Display segment driver on pins 7-4
    input  wire logic               iic_route,    // Two-wire bus routed to this port
    input  wire logic               iic_en,       // Two-wire bus enabled
    input  wire logic               iic_scl_out,  // Clock line level wanted, 0 pulls low
    input  wire logic               iic_sda_out,  // Data line level wanted, 0 pulls low
    input  wire logic               second_timer_unit_route,   // Second timer routed to this port
    input  wire logic [1:0]         second_timer_unit_oc_en,   // Its compare enables, pins 3-2
    input  wire logic [1:0]         second_timer_unit_oc_out,  // Its compare levels, pins 3-2
    input  wire logic               first_timer_unit_route,   // First timer routed to this port
    input  wire logic [1:0]         first_timer_unit_oc_en,   // Its compare enables, pins 1-0
    input  wire logic [1:0]         first_timer_unit_oc_out,  // Its compare levels, pins 1-0
    input  wire logic               can_route,    // Bus controller routed to this port
    input  wire logic               can_en,       // Bus controller enabled
    input  wire logic               can_tx        // Transmit level for pin 1
);
    import pdipc_pkg::*;

    pdipc_state_t st_q;      // Registered state
    pdipc_state_t st_d;      // Next state
    logic [7:0]   pin_sync;  // Pins after two flip-flops
    logic [7:0]   rb_val;    // Readback value
    logic [7:0]   is_out;    // Pin operates as output
    logic         iic_on;    // Two-wire bus owns pins 6-5
    logic         can_on;    // Bus controller owns pins 1-0 where no first timer compare is on

    // Pin level synchroniser
    pdipc_sync #(
        .W        (8)
    ) u_sync (
        .sys_clk  (sys_clk),
        .rst_b    (rst_b),
        .async_in (pin_in),
        .sync_out (pin_sync)
    );

    // Disabled input buffers read low
    assign rb_val = pin_sync & st_q.ie;
    assign iic_on = !lcd_en && iic_route && iic_en;
    assign can_on = can_route && can_en;

    // Register access, pin control and pull control
    always_comb begin
        st_d   = st_q;
        is_out = 8'h00;
        // Register writes
        if (wr) begin
            case (addr)
                `PDIPC_OFS_OUTPUT_LATCH:  st_d.latch = wdata;
                `PDIPC_OFS_PIN_DIRECTION: st_d.dir   = wdata;
                `PDIPC_OFS_PULL_ENABLE:   st_d.pe    = wdata;
                `PDIPC_OFS_PULL_POLARITY: st_d.pol   = wdata;
                default:                  st_d.latch = st_q.latch;
            endcase
        end
        // Register reads, data answered in the next cycle
        st_d.rdata = 8'h00;
        if (rd) begin
            case (addr)
                `PDIPC_OFS_OUTPUT_LATCH: begin
                    // Latch for outputs, pin for inputs
                    st_d.rdata = (st_q.latch & st_q.dir) | (rb_val & ~st_q.dir);
                end
                `PDIPC_OFS_PIN_READBACK:  st_d.rdata = rb_val;
                `PDIPC_OFS_PIN_DIRECTION: st_d.rdata = st_q.dir;
                `PDIPC_OFS_PULL_ENABLE:   st_d.rdata = st_q.pe;
                `PDIPC_OFS_PULL_POLARITY: st_d.rdata = st_q.pol;
                default:                  st_d.rdata = 8'h00;
            endcase
        end
        // Per-pin direction with peripheral overrides
        for (int i = 0; i < 8; i++) begin
            st_d.pout[i] = st_q.latch[i];
            st_d.oe[i]   = st_q.dir[i];
            st_d.ie[i]   = 1'h1;
            is_out[i]    = st_q.dir[i];
        end
        // Pins 3-2 follow the second timer compares
        for (int j = 0; j < 2; j++) begin
            if (second_timer_unit_route && second_timer_unit_oc_en[j]) begin
                st_d.oe[j+2]   = 1'h1;
                st_d.pout[j+2] = second_timer_unit_oc_out[j];
                is_out[j+2]    = 1'h1;
            end
        end
        // Pin 1: timer compare first, then transmit line
        if (first_timer_unit_route && first_timer_unit_oc_en[1]) begin
            st_d.oe[1]   = 1'h1;
            st_d.pout[1] = first_timer_unit_oc_out[1];
            is_out[1]    = 1'h1;
        end else if (can_on) begin
            st_d.oe[1]   = 1'h1;
            st_d.pout[1] = can_tx;
            is_out[1]    = 1'h1;
        end
        // Pin 0: timer compare first, then receive line
        if (first_timer_unit_route && first_timer_unit_oc_en[0]) begin
            st_d.oe[0]   = 1'h1;
            st_d.pout[0] = first_timer_unit_oc_out[0];
            is_out[0]    = 1'h1;
        end else if (can_on) begin
            st_d.oe[0]   = 1'h0;
            is_out[0]    = 1'h0;
        end
        // Pins 6-5 as open-drain, driving only a low level
        if (iic_on) begin
            st_d.pout[6] = 1'h0;
            st_d.oe[6]   = !iic_scl_out;
            st_d.pout[5] = 1'h0;
            st_d.oe[5]   = !iic_sda_out;
            is_out[6]    = 1'h1;
            is_out[5]    = 1'h1;
        end
        // Display driver takes pins 7-4 away from both buffers
        if (lcd_en) begin
            for (int k = 4; k < 8; k++) begin
                st_d.oe[k] = 1'h0;
                st_d.ie[k] = 1'h0;
                is_out[k]  = 1'h0;
            end
        end
        // Pull devices act only on pins used as inputs
        for (int i = 0; i < 8; i++) begin
            st_d.pull_en[i] = st_q.pe[i] && !is_out[i] && st_d.ie[i];
            st_d.pull_dn[i] = st_q.pol[i];
        end
        // Levels seen by the peripherals
        st_d.per_in = rb_val;
    end

    // Register the whole state
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q         <= '0;
            st_q.latch   <= `PDIPC_RST_OUTPUT_LATCH;
            st_q.dir     <= `PDIPC_RST_PIN_DIRECTION;
            st_q.pe      <= `PDIPC_RST_PULL_ENABLE;
            st_q.pol     <= `PDIPC_RST_PULL_POLARITY;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state flip-flops
    assign rdata   = st_q.rdata;
    assign pin_out = st_q.pout;
    assign pin_oe  = st_q.oe;
    assign pin_ie  = st_q.ie;
    assign pull_en = st_q.pull_en;
    assign pull_dn = st_q.pull_dn;
    assign per_in  = st_q.per_in;

    // Readback returns the pin level from three cycles before the answer
    property p_rb_read;
        @(posedge sys_clk) disable iff (!rst_b)
        (rd && addr == `PDIPC_OFS_PIN_READBACK && st_q.ie == `PDIPC_ALL_PINS)
        |=> (rdata == $past(pin_in, 3));
    endproperty
    a_rb_read: assert property (p_rb_read) else $error("readback value wrong");

    // A write to the readback leaves every register untouched
    property p_rb_write;
        @(posedge sys_clk) disable iff (!rst_b)
        (wr && addr == `PDIPC_OFS_PIN_READBACK)
        |=> ($stable(st_q.latch) && $stable(st_q.dir) && $stable(st_q.pe) && $stable(st_q.pol));
    endproperty
    a_rb_write: assert property (p_rb_write) else $error("readback write changed state");

    // Without overrides the output enables follow the direction register
    property p_dir;
        @(posedge sys_clk) disable iff (!rst_b)
        (!lcd_en && !iic_route && !second_timer_unit_route && !first_timer_unit_route && !can_route)
        |=> (pin_oe == $past(st_q.dir));
    endproperty
    a_dir: assert property (p_dir) else $error("output enable does not follow direction");

    // Display driver leaves pins 7-4 with both buffers off
    property p_lcd;
        @(posedge sys_clk) disable iff (!rst_b)
        lcd_en |=> (pin_oe[7:4] == 4'h0 && pin_ie[7:4] == 4'h0 && pull_en[7:4] == 4'h0);
    endproperty
    a_lcd: assert property (p_lcd) else $error("display pins still buffered");

    // Two-wire bus drives pins 6-5 only low
    property p_iic;
        @(posedge sys_clk) disable iff (!rst_b)
        (rst_b && iic_on) |=> (pin_out[6:5] == 2'h0 && pin_oe[6] == !$past(iic_scl_out)
                    && pin_oe[5] == !$past(iic_sda_out));
    endproperty
    a_iic: assert property (p_iic) else $error("two-wire pins not open-drain");

    // Second timer compare drives pin 2
    property p_second_timer_unit;
        @(posedge sys_clk) disable iff (!rst_b)
        (rst_b && second_timer_unit_route && second_timer_unit_oc_en[0])
        |=> (pin_oe[2] && pin_out[2] == $past(second_timer_unit_oc_out[0]));
    endproperty
    a_second_timer_unit: assert property (p_second_timer_unit) else $error("second timer compare not on pin 2");

    // Transmit line owns pin 1 when the first timer compare is off
    property p_can_tx;
        @(posedge sys_clk) disable iff (!rst_b)
        (rst_b && can_on && !(first_timer_unit_route && first_timer_unit_oc_en[1]))
        |=> (pin_oe[1] && pin_out[1] == $past(can_tx));
    endproperty
    a_can_tx: assert property (p_can_tx) else $error("transmit line not on pin 1");

    // Receive line makes pin 0 an input, timer compare wins over it
    property p_pin0;
        @(posedge sys_clk) disable iff (!rst_b)
        (rst_b && can_on) |=> (pin_oe[0] == $past(first_timer_unit_route && first_timer_unit_oc_en[0]));
    endproperty
    a_pin0: assert property (p_pin0) else $error("pin 0 direction wrong");

    // A data read of an input pin answers the pin level of three cycles before
    property p_data_in;
        @(posedge sys_clk) disable iff (!rst_b)
        (rd && addr == `PDIPC_OFS_OUTPUT_LATCH && st_q.dir == `PDIPC_NO_PINS
         && st_q.ie == `PDIPC_ALL_PINS) |=> (rdata == $past(pin_in, 3));
    endproperty
    a_data_in: assert property (p_data_in) else $error("input read latency wrong");

    // A data read of output pins answers the latch
    property p_data_out;
        @(posedge sys_clk) disable iff (!rst_b)
        (rd && addr == `PDIPC_OFS_OUTPUT_LATCH && st_q.dir == `PDIPC_ALL_PINS)
        |=> (rdata == $past(st_q.latch));
    endproperty
    a_data_out: assert property (p_data_out) else $error("output read not from latch");

    // Input pins with no override take the pull enable
    property p_pull_in;
        @(posedge sys_clk) disable iff (!rst_b)
        (rst_b && st_q.dir == `PDIPC_NO_PINS && !lcd_en && !iic_route && !second_timer_unit_route
         && !first_timer_unit_route && !can_route) |=> (pull_en == $past(st_q.pe));
    endproperty
    a_pull_in: assert property (p_pull_in) else $error("pull enable not applied");

    // No pull is active on a pin whose output driver is on
    property p_pull_out;
        @(posedge sys_clk) disable iff (!rst_b)
        ((pin_oe & pull_en) == 8'h00);
    endproperty
    a_pull_out: assert property (p_pull_out) else $error("pull active on output");

    // Pull polarity follows the polarity select one cycle later
    property p_pull_pol;
        @(posedge sys_clk) disable iff (!rst_b)
        1'b1 |=> (pull_dn == $past(st_q.pol));
    endproperty
    a_pull_pol: assert property (p_pull_pol) else $error("pull polarity wrong");

    // Pin 3 follows the second timer compare as well
    property p_second_timer_unit_hi;
        @(posedge sys_clk) disable iff (!rst_b)
        (rst_b && second_timer_unit_route && second_timer_unit_oc_en[1])
        |=> (pin_oe[3] && pin_out[3] == $past(second_timer_unit_oc_out[1]));
    endproperty
    a_second_timer_unit_hi: assert property (p_second_timer_unit_hi) else $error("pin 3 not on timer compare");

    // Pull enables and direction leave reset at their reset values
    property p_rst_regs;
        @(posedge sys_clk) disable iff (!rst_b)
        $rose(rst_b)
        |-> (st_q.pe == `PDIPC_RST_PULL_ENABLE && st_q.dir == `PDIPC_RST_PIN_DIRECTION);
    endproperty
    a_rst_regs: assert property (p_rst_regs) else $error("registers not at reset values");

    // A cleared pull enable keeps its pull device off
    property p_pull_off;
        @(posedge sys_clk) disable iff (!rst_b)
        rst_b
        |=> ((pull_en & ~$past(st_q.pe)) == 8'h00);
    endproperty
    a_pull_off: assert property (p_pull_off) else $error("pull active while disabled");

endmodule

`default_nettype wire

// ### testbench/pdipc_pads.sv
/*
 * Pad model of the eight port pins: resolves each pin level from the
 * block's drive, an outside driver, a forced short and the pull device.
 * Assumes the bench drives the outside driver and short controls.
 */
`timescale 1ns/1ns
`default_nettype none

module pdipc_pads (
    input  wire logic       sys_clk,    // System clock
    input  wire logic [7:0] pin_out,    // Block drive level
    input  wire logic [7:0] pin_oe,     // Block drive enable
    input  wire logic [7:0] pull_en,    // Pull device active
    input  wire logic [7:0] pull_dn,    // Pull-down when high
    input  wire logic [7:0] ext_drv,    // Outside driver enable
    input  wire logic [7:0] ext_val,    // Outside driver level
    input  wire logic [7:0] short_en,   // Pin shorted to a fixed level
    input  wire logic [7:0] short_val,  // Level of the short
    output logic      [7:0] pin_in      // Resolved pin level
);
    logic [7:0] last_q = 8'h00;         // Level seen last cycle

    // Floating pins toggle so no stale level passes for a real one
    always_ff @(posedge sys_clk) begin
        last_q <= pin_in;
    end

    // Short beats block drive, which beats outside drive, then pull
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (short_en[i]) begin
                pin_in[i] = short_val[i];
            end else if (pin_oe[i]) begin
                pin_in[i] = pin_out[i];
            end else if (ext_drv[i]) begin
                pin_in[i] = ext_val[i];
            end else if (pull_en[i]) begin
                pin_in[i] = ~pull_dn[i];
            end else begin
                pin_in[i] = ~last_q[i];
            end
        end
    end
endmodule
`default_nettype wire

// ### testbench/pdipc_top_tb.sv
/*
 * Self-checking bench of the port controller: random register and
 * peripheral settings, pin levels through a pad model, register reads.
 * Assumes the constants header and the package are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none
`include "pdipc_defines.svh"

module pdipc_top_tb;
    import pdipc_pkg::*;
    typedef struct packed {
        logic [7:0] oe, out, ie, pu;                  // Expected pin controls
    } pdipc_exp_t;
    logic sys_clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0;
    pdipc_addr_t addr = 16'h0000;                     // Bus address
    pdipc_byte_t wdata = 8'h00, rdata;                // Bus data
    logic [7:0]  pin_in, pin_out, pin_oe, pin_ie, pull_en, pull_dn, per_in;
    logic lcd_en = 0, iic_route = 0, iic_en = 0, iic_scl_out = 0, iic_sda_out = 0;
    logic second_timer_unit_route = 0, first_timer_unit_route = 0, can_route = 0, can_en = 0, can_tx = 0;
    logic [1:0]  second_timer_unit_oc_en = 0, second_timer_unit_oc_out = 0, first_timer_unit_oc_en = 0, first_timer_unit_oc_out = 0;
    logic [7:0]  ext_drv = 0, ext_val = 0, short_en = 0, short_val = 0;
    logic [7:0]  sh_latch, sh_dir, sh_pe, sh_pol;     // Register shadows
    integer      seed = 32'hc7cd;                     // Fixed seed
    int          err_count = 0, compares = 0, cyc = 0;
    logic [31:0] v;                                   // Random word

    pdipc_top i_pdipc_top (.sys_clk, .rst_b, .addr, .wdata, .wr, .rd, .rdata, .pin_in,
        .pin_out, .pin_oe, .pin_ie, .pull_en, .pull_dn, .per_in, .lcd_en, .iic_route,
        .iic_en, .iic_scl_out, .iic_sda_out, .second_timer_unit_route, .second_timer_unit_oc_en, .second_timer_unit_oc_out,
        .first_timer_unit_route, .first_timer_unit_oc_en, .first_timer_unit_oc_out, .can_route, .can_en, .can_tx);
    pdipc_pads i_pdipc_pads (.sys_clk, .pin_out, .pin_oe, .pull_en, .pull_dn, .ext_drv,
        .ext_val, .short_en, .short_val, .pin_in);

    // Clock of 4 ns
    initial begin
        forever #2 sys_clk = ~sys_clk;
    end

    // Cuts a hang short
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end

    // Prints the counts and the verdict, then stops
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Masked byte compare
    task automatic chk(string nm, logic [7:0] e, logic [7:0] g, logic [7:0] m);
        compares++;
        if ((g & m) !== (e & m)) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, e & m, g & m);
        end
    endtask

    // One write cycle, shadows follow the mapped registers
    task automatic bus_wr(logic [15:0] a, logic [7:0] d);
        @(posedge sys_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge sys_clk);
        wr <= 1'b0;
        case (a)
            `PDIPC_OFS_OUTPUT_LATCH:  sh_latch = d;
            `PDIPC_OFS_PIN_DIRECTION: sh_dir = d;
            `PDIPC_OFS_PULL_ENABLE:   sh_pe = d;
            `PDIPC_OFS_PULL_POLARITY: sh_pol = d;
            default: ;
        endcase
    endtask

    // One read cycle, data taken in the following cycle
    task automatic bus_rd(logic [15:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    // Resets the block and the shadows
    task automatic do_reset();
        rst_b <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        {sh_latch, sh_dir, sh_pe, sh_pol} = {8'h00, 8'h00, 8'hFF, 8'h00};
        repeat (4) @(posedge sys_clk);
    endtask

    // Expected pin controls from shadows and peripheral inputs
    function automatic pdipc_exp_t exp_pins();
        pdipc_exp_t e;
        logic [7:0] od;
        e = {sh_dir, sh_latch, 8'hFF, 8'h00};
        od = 8'h00;
        for (int i = 0; i < 2; i++) begin
            if (second_timer_unit_route && second_timer_unit_oc_en[i]) begin
                e.oe[i+2] = 1'b1;
                e.out[i+2] = second_timer_unit_oc_out[i];
            end
        end
        if (first_timer_unit_route && first_timer_unit_oc_en[1]) begin
            {e.oe[1], e.out[1]} = {1'b1, first_timer_unit_oc_out[1]};
        end else if (can_route && can_en) begin
            {e.oe[1], e.out[1]} = {1'b1, can_tx};
        end
        if (first_timer_unit_route && first_timer_unit_oc_en[0]) begin
            {e.oe[0], e.out[0]} = {1'b1, first_timer_unit_oc_out[0]};
        end else if (can_route && can_en) begin
            e.oe[0] = 1'b0;
        end
        if (!lcd_en && iic_route && iic_en) begin
            od = 8'h60;
            e.out[6:5] = 2'b00;
            e.oe[6:5] = ~{iic_scl_out, iic_sda_out};
        end
        if (lcd_en) begin
            e.oe[7:4] = 4'h0;
            e.ie[7:4] = 4'h0;
        end
        e.pu = sh_pe & ~e.oe & e.ie & ~od;
        return e;
    endfunction

    // Compares every pin output and every register read
    task automatic check_all();
        pdipc_exp_t e;
        logic [7:0] lv, kn, rb, d, dm;
        @(posedge sys_clk);
        #1;
        e = exp_pins();
        lv = (short_en & short_val) | (~short_en & e.oe & e.out)
           | (~short_en & ~e.oe & ((ext_drv & ext_val) | (~ext_drv & e.pu & ~sh_pol)));
        kn = short_en | e.oe | ext_drv | e.pu | ~e.ie;
        rb = lv & e.ie;
        dm = (sh_dir & e.ie) | (~sh_dir & kn);
        chk("pin_oe", e.oe, pin_oe, 8'hFF);
        chk("pin_out", e.out, pin_out, e.oe);
        chk("pin_ie", e.ie, pin_ie, 8'hFF);
        chk("pull_en", e.pu, pull_en, 8'hFF);
        chk("pull_dn", sh_pol, pull_dn, 8'hFF);
        chk("per_in", rb, per_in, kn);
        bus_rd(`PDIPC_OFS_PIN_READBACK, d);
        chk("readback", rb, d, kn);
        bus_rd(`PDIPC_OFS_OUTPUT_LATCH, d);
        chk("data", (sh_dir & sh_latch) | (~sh_dir & rb), d, dm);
        bus_rd(`PDIPC_OFS_PIN_DIRECTION, d);
        chk("direction", sh_dir, d, 8'hFF);
        bus_rd(`PDIPC_OFS_PULL_ENABLE, d);
        chk("pull_enable", sh_pe, d, 8'hFF);
        bus_rd(`PDIPC_OFS_PULL_POLARITY, d);
        chk("polarity", sh_pol, d, 8'hFF);
        bus_rd(16'h0283, d);
        chk("unmapped", 8'h00, d, 8'hFF);
    endtask

    // Main sequence
    initial begin
        logic [7:0] d;
        do_reset();
        check_all();
        bus_wr(`PDIPC_OFS_PIN_READBACK, 8'h5A);
        bus_wr(16'h0283, 8'hA5);
        check_all();
        ext_drv <= 8'hFF;
        ext_val <= 8'h5A;
        bus_wr(`PDIPC_OFS_OUTPUT_LATCH, 8'hC3);
        bus_wr(`PDIPC_OFS_PIN_DIRECTION, 8'hFF);
        bus_rd(`PDIPC_OFS_OUTPUT_LATCH, d);
        chk("data_early", 8'hC3, d, 8'hFF);
        for (int n = 0; n < 80; n++) begin
            if (n == 40) begin
                do_reset();
                check_all();
            end
            v = $random(seed);
            @(posedge sys_clk);
            {lcd_en, iic_route, iic_en, iic_scl_out, iic_sda_out} <= v[4:0];
            {second_timer_unit_route, first_timer_unit_route, can_route, can_en, can_tx} <= v[9:5];
            {second_timer_unit_oc_en, second_timer_unit_oc_out, first_timer_unit_oc_en, first_timer_unit_oc_out} <= v[17:10];
            ext_drv <= v[25:18];
            ext_val <= v[31:24];
            short_en <= (n % 4 == 0) ? v[7:0] & v[15:8] : 8'h00;
            short_val <= v[23:16];
            v = $random(seed);
            bus_wr(`PDIPC_OFS_OUTPUT_LATCH, v[7:0]);
            bus_wr(`PDIPC_OFS_PIN_DIRECTION, v[15:8]);
            bus_wr(`PDIPC_OFS_PULL_ENABLE, v[23:16]);
            bus_wr(`PDIPC_OFS_PULL_POLARITY, v[31:24]);
            repeat (4) @(posedge sys_clk);
            check_all();
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
